// *** pkg/dcpm_pkg.sv ***
// Purpose: shared constants and types of the dual rc clock and power mode controller
// Assumes: byte-wide registers on a 9-bit register address
// Notes: one number per name, the design uses only these names
package dcpm_pkg;
	// register bus shape
	localparam int DCPM_AW = 9;
	localparam int DCPM_DW = 8;
	// register offsets
	localparam logic [8:0] DCPM_OFS_IRQ_EN = 9'h00b;
	localparam logic [8:0] DCPM_OFS_CLK_CTL = 9'h00f;
	localparam logic [8:0] DCPM_OFS_TRIM = 9'h10f;
	localparam logic [8:0] DCPM_OFS_STATUS = 9'h1e0;
	// reset values
	localparam logic [7:0] DCPM_IRQ_EN_RST = 8'h00;
	localparam logic [7:0] DCPM_CLK_CTL_RST = 8'h0b;
	localparam logic [6:0] DCPM_TRIM_RST = 7'h00;
	// writable bit masks, reserved bits read as zero
	localparam logic [7:0] DCPM_IRQ_EN_MASK = 8'hbf;
	localparam logic [7:0] DCPM_CLK_CTL_MASK = 8'h1f;
	// field positions of system_clock_control
	localparam int DCPM_SLOW_HALT_BIT = 4;
	localparam int DCPM_FAST_HALT_BIT = 3;
	localparam int DCPM_SRC_SEL_BIT = 2;
	localparam int DCPM_DIV_LSB = 0;
	// field positions of interrupt_enable_reg
	localparam int DCPM_WKT_EN_BIT = 3;
	localparam int DCPM_PIN_EN_LSB = 0;
	// prescaler codes and their terminal counts
	localparam logic [1:0] DCPM_DIV8 = 2'h0;
	localparam logic [1:0] DCPM_DIV4 = 2'h1;
	localparam logic [1:0] DCPM_DIV2 = 2'h2;
	localparam logic [1:0] DCPM_DIV1 = 2'h3;
	localparam logic [2:0] DCPM_DIV8_MAX = 3'h7;
	localparam logic [2:0] DCPM_DIV4_MAX = 3'h3;
	localparam logic [2:0] DCPM_DIV2_MAX = 3'h1;
	localparam logic [2:0] DCPM_DIV1_MAX = 3'h0;
	// watchdog mode that keeps the slow oscillator alive in sleep
	localparam logic [1:0] DCPM_WDT_ALWAYS = 2'h3;
	// pwm clock select codes
	localparam logic [1:0] DCPM_PWM_SYS = 2'h0;
	localparam logic [1:0] DCPM_PWM_FAST256 = 2'h1;
	localparam logic [1:0] DCPM_PWM_FAST = 2'h2;
	localparam logic [1:0] DCPM_PWM_FAST2X = 2'h3;
	// fast oscillator over 256 prescale terminal count
	localparam logic [7:0] DCPM_FAST256_MAX = 8'hff;
	// operating modes
	typedef enum logic [1:0] {
		DCPM_FAST = 2'b00,
		DCPM_SLOW = 2'b01,
		DCPM_IDLE = 2'b10,
		DCPM_STOP = 2'b11
	} dcpm_mode_t;
endpackage

// *** rtl/dcpm_clock_ctrl.sv ***
// Purpose: system clock source, prescaler, trim and sleep mode sequencing
// Assumes: oscillator edges arrive as one-cycle ticks synchronous to core_clk
// Notes: clocks leave as tick pulses, peripherals use them as enables
//
// Contract
// [R1] reset leaves device in slow mode
// [R2] hardware blocks halting fast while selecting it
// [R3] software changes clock control one bit
// [R4] trim value raises fast frequency monotonically
// [R5] trim power-on default is per chip
// [R6] fast mode clocks cpu and timers fast
// [R7] pwm clock picks from four sources
// [R8] slow mode clocks peripherals from slow
// [R9] sleep enters idle if slow keeps running
// [R10] idle ends on reset or enabled wake
// [R11] sleep enters stop when nothing needs slow
// [R12] stop exits only on pin events
// [R13] watchdog mode three forbids stop
// [R14] fast to slow: select slow, then halt
// [R15] slow to fast: unhalt, wait, then select
// [R16] slow halt bit acts only in sleep
// [R17] fast halt bit stops fast oscillator
// [R18] source bit picks slow or fast clock
// [R19] prescaler divides by eight four two one
// [R20] wakeup enable runs timer and interrupt
// [R21] fast oscillator usable directly as sysclk
// [R22] source and divider switch without runt pulses
// [R23] wake resumes previous source and divider
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module dcpm_clock_ctrl
	import dcpm_pkg::*;
(
	input wire logic core_clk, // system clock, 125 MHz
	input wire logic rst, // asynchronous, active high
	input wire logic [8:0] reg_addr, // register byte address
	input wire logic [7:0] reg_wr_data, // write data
	input wire logic reg_wr_en, // write strobe
	input wire logic reg_rd_en, // read strobe
	output logic [7:0] reg_rd_data, // read data, cycle after strobe
	input wire logic [6:0] trim_default, // per-chip trim strap
	input wire logic slow_osc_tick, // slow oscillator edge
	input wire logic fast_osc_tick, // fast oscillator edge
	input wire logic fast_x2_tick, // doubled fast oscillator edge
	input wire logic [1:0] pwm_clock_sel, // pwm source select field
	input wire logic [1:0] watchdog_mode_cfg, // watchdog mode setting
	input wire logic sleep_req, // sleep instruction executed
	input wire logic wakeup_timer_irq, // wakeup timer timeout
	input wire logic [2:0] ext_pin_irq, // external pin interrupt events
	input wire logic pin_change_evt, // port pin-change event
	input wire logic pin_change_en, // pin-change wake enable
	output logic sysclk_tick, // divided system clock edge
	output logic timer_tick, // general timer a and b clock edge
	output logic pwm_tick, // pwm unit clock edge
	output logic slow_osc_en, // slow oscillator run control
	output logic fast_osc_en, // fast oscillator run control
	output logic [6:0] fast_rc_trim, // trim code to the fast oscillator
	output logic wakeup_timer_run, // wakeup timer count enable
	output logic watchdog_clk_run, // watchdog clock available
	output dcpm_mode_t op_mode // current operating mode
);

	// register storage
	logic [7:0] irq_en; // interrupt_enable_reg
	logic [7:0] clk_ctl; // system_clock_control
	logic trim_loaded; // strap captured after reset release

	// applied clock settings, lag the register until a safe boundary
	logic act_src; // source feeding the divider
	logic [1:0] act_div; // prescaler code in force
	logic [2:0] div_cnt; // prescaler count
	logic [2:0] div_max; // terminal count of act_div
	logic [7:0] fast256_cnt; // fast over 256 counter

	// decoded control fields
	logic slow_halt_in_sleep;
	logic fast_osc_halt;
	logic sysclk_source_sel;
	logic [1:0] sysclk_divider;
	logic wakeup_timer_irq_en;
	logic [2:0] pin_irq_en;

	// combinational helpers
	logic awake; // fast or slow mode
	logic fast_live; // fast tick while its oscillator runs
	logic slow_live; // slow tick while its oscillator runs
	logic src_tick; // edge of the applied source
	logic boundary; // end of a whole divided period
	logic idle_wake; // enabled wake for idle
	logic stop_wake; // enabled wake for stop
	logic keep_slow; // slow oscillator must stay alive in sleep
	logic switch_pending; // register differs from applied setting
	logic [7:0] next_clk_ctl; // filtered write value
	logic [7:0] status; // readable mode status

	assign slow_halt_in_sleep = clk_ctl[DCPM_SLOW_HALT_BIT];
	assign fast_osc_halt = clk_ctl[DCPM_FAST_HALT_BIT];
	assign sysclk_source_sel = clk_ctl[DCPM_SRC_SEL_BIT];
	assign sysclk_divider = clk_ctl[DCPM_DIV_LSB +: 2];
	assign wakeup_timer_irq_en = irq_en[DCPM_WKT_EN_BIT];
	assign pin_irq_en = irq_en[DCPM_PIN_EN_LSB +: 3];

	// oscillator ticks only count while the run control is high
	always_comb begin
		awake = (op_mode == DCPM_FAST) || (op_mode == DCPM_SLOW);
		fast_live = fast_osc_tick && fast_osc_en;
		slow_live = slow_osc_tick && slow_osc_en;
		src_tick = act_src ? fast_live : slow_live; // [R18] [R21]
	end

	// terminal count of the prescaler in force
	always_comb begin
		unique case (act_div)
			DCPM_DIV8: div_max = DCPM_DIV8_MAX; // [R19]
			DCPM_DIV4: div_max = DCPM_DIV4_MAX; // [R19]
			DCPM_DIV2: div_max = DCPM_DIV2_MAX; // [R19]
			DCPM_DIV1: div_max = DCPM_DIV1_MAX; // [R19]
		endcase
	end

	// settings change only where a whole output period has ended
	assign boundary = src_tick && (div_cnt == div_max); // [R22]

	// sleep decision and wake qualification
	always_comb begin
		// any one keeper holds the slow oscillator in sleep
		keep_slow = !slow_halt_in_sleep || wakeup_timer_irq_en ||
			(watchdog_mode_cfg == DCPM_WDT_ALWAYS); // [R9] [R13] [R16]
		// idle accepts timer and external pin wakes, gated by their enables; pin change does not wake it
		idle_wake = (wakeup_timer_irq && wakeup_timer_irq_en) ||
			(|(ext_pin_irq & pin_irq_en)); // [R10]
		// stop has no clock, so only pins can wake it
		stop_wake = (|(ext_pin_irq & pin_irq_en)) ||
			(pin_change_evt && pin_change_en); // [R12]
		switch_pending = (act_src != sysclk_source_sel) || (act_div != sysclk_divider);
	end

	// write filter for system_clock_control
	always_comb begin
		next_clk_ctl = reg_wr_data & DCPM_CLK_CTL_MASK;
		// a write that halts fast while selecting it keeps both old bits
		if (next_clk_ctl[DCPM_FAST_HALT_BIT] && next_clk_ctl[DCPM_SRC_SEL_BIT]) begin
			next_clk_ctl[DCPM_FAST_HALT_BIT] = clk_ctl[DCPM_FAST_HALT_BIT]; // [R2]
			next_clk_ctl[DCPM_SRC_SEL_BIT] = clk_ctl[DCPM_SRC_SEL_BIT]; // [R2]
		end
		// the applied fast source may not be halted under the cpu
		if (next_clk_ctl[DCPM_FAST_HALT_BIT] && act_src) begin
			next_clk_ctl[DCPM_FAST_HALT_BIT] = clk_ctl[DCPM_FAST_HALT_BIT]; // [R2] [R14]
		end
	end

	// clock control register, software owned
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			clk_ctl <= DCPM_CLK_CTL_RST; // [R1]
		end else if (reg_wr_en && (reg_addr == DCPM_OFS_CLK_CTL)) begin
			clk_ctl <= next_clk_ctl; // [R17] [R18] [R19]
		end
	end

	// interrupt enable register, bit 6 reserved
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_en <= DCPM_IRQ_EN_RST;
		end else if (reg_wr_en && (reg_addr == DCPM_OFS_IRQ_EN)) begin
			irq_en <= reg_wr_data & DCPM_IRQ_EN_MASK; // [R20]
		end
	end

	// trim register, strap loaded on the first edge after reset release
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fast_rc_trim <= DCPM_TRIM_RST;
			trim_loaded <= 1'b0;
		end else if (!trim_loaded) begin
			// strap cannot be taken under the async reset itself
			fast_rc_trim <= trim_default; // [R5]
			trim_loaded <= 1'b1;
		end else if (reg_wr_en && (reg_addr == DCPM_OFS_TRIM)) begin
			// code passes straight through, oscillator rises with it
			fast_rc_trim <= reg_wr_data[6:0]; // [R4]
		end
	end

	// operating mode sequencer
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			op_mode <= DCPM_SLOW; // [R1]
		end else begin
			unique case (op_mode)
				DCPM_FAST, DCPM_SLOW: begin
					if (sleep_req) begin
						// watchdog mode three always lands in idle
						op_mode <= keep_slow ? DCPM_IDLE : DCPM_STOP; // [R9] [R11] [R13]
					end else begin
						op_mode <= act_src ? DCPM_FAST : DCPM_SLOW; // [R6] [R8]
					end
				end
				DCPM_IDLE: begin
					// resume on the source still held in act_src
					if (idle_wake) begin
						op_mode <= act_src ? DCPM_FAST : DCPM_SLOW; // [R10] [R23]
					end
				end
				DCPM_STOP: begin
					if (stop_wake) begin
						op_mode <= act_src ? DCPM_FAST : DCPM_SLOW; // [R12] [R23]
					end
				end
			endcase
		end
	end

	// oscillator run controls
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			slow_osc_en <= 1'b1; // [R1]
			fast_osc_en <= 1'b0;
		end else begin
			// slow stops only in stop; halt bit is ignored while awake
			// it restarts on the waking edge so the resumed mode has its source
			slow_osc_en <= ((op_mode != DCPM_STOP) &&
				!(awake && sleep_req && !keep_slow)) ||
				((op_mode == DCPM_STOP) && stop_wake); // [R11] [R16] [R23]
			// fast follows its halt bit while awake and stops in sleep
			// a wake back into fast mode must find the oscillator running
			fast_osc_en <= !fast_osc_halt && ((awake && !sleep_req) ||
				((op_mode == DCPM_IDLE) && idle_wake) ||
				((op_mode == DCPM_STOP) && stop_wake)); // [R17] [R8] [R23]
		end
	end

	// glitch-free prescaler and source switch
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			div_cnt <= 3'h0;
			act_src <= 1'b0; // [R1]
			act_div <= DCPM_DIV1;
		end else if (!awake) begin
			// restart cleanly so the first period after wake is whole
			div_cnt <= 3'h0; // [R23]
		end else if (boundary) begin
			div_cnt <= 3'h0;
			// fast is taken only once its oscillator is running
			if (!sysclk_source_sel || fast_osc_en) begin
				act_src <= sysclk_source_sel; // [R22] [R15]
			end
			act_div <= sysclk_divider; // [R22]
		end else if (src_tick) begin
			div_cnt <= div_cnt + 3'h1;
		end
	end

	// system clock edge, only while awake
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sysclk_tick <= 1'b0;
		end else begin
			sysclk_tick <= awake && !sleep_req && boundary; // [R19] [R21]
		end
	end

	// general timers run on the undivided applied source
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			timer_tick <= 1'b0;
		end else begin
			timer_tick <= awake && !sleep_req && src_tick; // [R6] [R8]
		end
	end

	// fast over 256 prescale for the pwm unit
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fast256_cnt <= 8'h00;
		end else if (fast_live) begin
			fast256_cnt <= fast256_cnt + 8'h01;
		end
	end

	// pwm unit clock keeps its own selection in every awake mode
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pwm_tick <= 1'b0;
		end else if (!awake) begin
			pwm_tick <= 1'b0;
		end else begin
			unique case (pwm_clock_sel)
				DCPM_PWM_SYS: pwm_tick <= !sleep_req && boundary; // [R7]
				DCPM_PWM_FAST256: pwm_tick <= fast_live && (fast256_cnt == DCPM_FAST256_MAX); // [R7]
				DCPM_PWM_FAST: pwm_tick <= fast_live; // [R7]
				DCPM_PWM_FAST2X: pwm_tick <= fast_x2_tick && fast_osc_en; // [R7]
			endcase
		end
	end

	// wakeup timer and watchdog clock availability
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wakeup_timer_run <= 1'b0;
			watchdog_clk_run <= 1'b1;
		end else begin
			// clearing the enable stops the timer, stop mode also stops it
			wakeup_timer_run <= wakeup_timer_irq_en && (op_mode != DCPM_STOP); // [R20] [R12]
			// off from the first stop cycle, back on the waking edge
			watchdog_clk_run <= ((op_mode != DCPM_STOP) &&
				!(awake && sleep_req && !keep_slow)) ||
				((op_mode == DCPM_STOP) && stop_wake); // [R11] [R12]
		end
	end

	// status view of the block's own state
	always_comb begin
		status = 8'h00;
		status[1:0] = op_mode;
		status[2] = act_src;
		status[3] = fast_osc_en;
		status[4] = slow_osc_en;
		status[5] = switch_pending;
	end

	// read port, data one cycle after the strobe, else zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rd_data <= 8'h00;
		end else if (reg_rd_en) begin
			unique case (reg_addr)
				DCPM_OFS_IRQ_EN: reg_rd_data <= irq_en;
				DCPM_OFS_CLK_CTL: reg_rd_data <= clk_ctl;
				DCPM_OFS_TRIM: reg_rd_data <= {1'b0, fast_rc_trim};
				DCPM_OFS_STATUS: reg_rd_data <= status;
				// unmapped addresses read as zero
				default: reg_rd_data <= 8'h00;
			endcase
		end else begin
			reg_rd_data <= 8'h00;
		end
	end

endmodule // dcpm_clock_ctrl

// *** tb/dcpm_clock_ctrl_bench.sv ***
// Purpose: self-checking bench of dcpm_clock_ctrl
// Assumes: slow edge every 8 cycles, fast every 2
// Notes: reads are checked from a queue one cycle after the strobe
`timescale 1ns/1ps
module dcpm_clock_ctrl_bench;
	import dcpm_pkg::*;
	localparam logic [6:0] TRIM_STRAP = 7'h5a; // arbitrary strap
	// sleep cases: halt, wkt, wdt[1:0], pin change, mode
	localparam logic [6:0] CASES [5] = '{7'h02, 7'h62, 7'h5a, 7'h57, 7'h4f};
	localparam int PWM_EXP [4] = '{64, 1, 256, 512}; // per 512 cycles
	logic core_clk, rst, reg_wr_en, reg_rd_en, sleep_req, wakeup_timer_irq;
	logic pin_change_evt, pin_change_en, slow_osc_tick, fast_osc_tick, fast_x2_tick;
	logic sysclk_tick, timer_tick, pwm_tick, slow_osc_en, fast_osc_en;
	logic wakeup_timer_run, watchdog_clk_run, rd_d;
	logic [8:0] reg_addr;
	logic [7:0] reg_wr_data, reg_rd_data, exp_q[$], msk_q[$];
	logic [6:0] fast_rc_trim;
	logic [6:0] cs;
	logic [1:0] pwm_clock_sel, watchdog_mode_cfg;
	logic [2:0] ext_pin_irq;
	logic [31:0] rng = 32'h985d53c6;
	dcpm_mode_t op_mode;
	int fails = 0, compares = 0, n_sys = 0, n_pwm = 0, ds, dp;
	dcpm_clock_ctrl i_dut (.core_clk, .rst, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en,
		.reg_rd_data, .trim_default(TRIM_STRAP), .slow_osc_tick, .fast_osc_tick, .fast_x2_tick,
		.pwm_clock_sel, .watchdog_mode_cfg, .sleep_req, .wakeup_timer_irq, .ext_pin_irq,
		.pin_change_evt, .pin_change_en, .sysclk_tick, .timer_tick, .pwm_tick, .slow_osc_en,
		.fast_osc_en, .fast_rc_trim, .wakeup_timer_run, .watchdog_clk_run, .op_mode);
	dcpm_osc_model i_osc (.core_clk, .slow_osc_en, .fast_osc_en, .slow_osc_tick,
		.fast_osc_tick, .fast_x2_tick);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr_en <= 1'b1;
		@(posedge core_clk);
		reg_wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [8:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge core_clk);
		reg_rd_en <= 1'b0;
	endtask
	// one-cycle event pulse: sleep, wkt, pin change, ext pins
	task automatic pulse(input logic [5:0] v);
		@(posedge core_clk);
		{sleep_req, wakeup_timer_irq, pin_change_evt, ext_pin_irq} <= v;
		@(posedge core_clk);
		{sleep_req, wakeup_timer_irq, pin_change_evt, ext_pin_irq} <= 6'h00;
	endtask
	// counts over a window that is a whole number of source periods
	task automatic win(input int n);
		int s0;
		int p0;
		@(negedge core_clk);
		s0 = n_sys;
		p0 = n_pwm;
		repeat (n) @(negedge core_clk);
		ds = n_sys - s0;
		dp = n_pwm - p0;
	endtask
	task automatic print_verdict;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// tick counters and read answer monitor
	always @(posedge core_clk) begin
		n_sys <= n_sys + int'(sysclk_tick);
		n_pwm <= n_pwm + int'(pwm_tick);
		rd_d <= reg_rd_en;
	end
	always @(negedge core_clk) begin
		if (rd_d) chk("reg_rd_data", exp_q.pop_front(), reg_rd_data & msk_q.pop_front());
	end
	// hang guard
	initial begin
		cyc(30000);
		fails++;
		$display("mismatch watchdog expected finish seen timeout");
		print_verdict();
	end
	initial begin
		{rst, reg_wr_en, reg_rd_en, sleep_req, wakeup_timer_irq, pin_change_evt} = 6'h20;
		{reg_addr, reg_wr_data, ext_pin_irq, pwm_clock_sel, watchdog_mode_cfg} = '0;
		pin_change_en = 1'b1;
		cyc(8);
		rst <= 1'b0;
		cyc(2);
		rd(DCPM_OFS_IRQ_EN, 8'h00, 8'hff);
		rd(DCPM_OFS_CLK_CTL, 8'h0b, 8'hff);
		rd(DCPM_OFS_TRIM, {1'b0, TRIM_STRAP}, 8'hff);
		rd(DCPM_OFS_STATUS, 8'h11, 8'h1f);
		wr(9'h1ff, 8'hff);
		rd(9'h1ff, 8'h00, 8'hff);
		$display("test reset values done");
		for (int i = 0; i < 4; i++) begin
			rng = xs(rng);
			wr(DCPM_OFS_IRQ_EN, rng[7:0]);
			wr(DCPM_OFS_TRIM, rng[15:8]);
			rd(DCPM_OFS_IRQ_EN, rng[7:0] & 8'hbf, 8'hff);
			rd(DCPM_OFS_TRIM, rng[15:8] & 8'h7f, 8'hff);
			chk("fast_rc_trim", rng[14:8], fast_rc_trim);
			chk("wakeup_timer_run", rng[3], wakeup_timer_run);
		end
		wr(DCPM_OFS_IRQ_EN, 8'h00);
		$display("test register access done");
		wr(DCPM_OFS_CLK_CTL, 8'h0e);
		rd(DCPM_OFS_CLK_CTL, 8'h0a, 8'hff);
		wr(DCPM_OFS_CLK_CTL, 8'h03);
		cyc(2);
		wr(DCPM_OFS_CLK_CTL, 8'h07);
		cyc(40);
		rd(DCPM_OFS_STATUS, 8'h1c, 8'h3f);
		win(64);
		chk("sysclk ticks fast", 32, ds);
		wr(DCPM_OFS_CLK_CTL, 8'h0f);
		rd(DCPM_OFS_CLK_CTL, 8'h07, 8'hff);
		wr(DCPM_OFS_CLK_CTL, 8'h03);
		cyc(40);
		wr(DCPM_OFS_CLK_CTL, 8'h0b);
		rd(DCPM_OFS_STATUS, 8'h11, 8'h3f);
		$display("test source switch done");
		for (int c = 0; c < 4; c++) begin
			wr(DCPM_OFS_CLK_CTL, 8'(c));
			cyc(80);
			win(256);
			chk("sysclk ticks", 32 >> (3 - c), ds);
		end
		for (int k = 0; k < 4; k++) begin
			pwm_clock_sel <= 2'(k);
			cyc(20);
			win(512);
			chk("pwm ticks", PWM_EXP[k], dp);
		end
		$display("test dividers done");
		for (int j = 0; j < 5; j++) begin
			cs = CASES[j];
			wr(DCPM_OFS_IRQ_EN, {4'h0, cs[5], 3'h1});
			wr(DCPM_OFS_CLK_CTL, {3'h0, cs[6], 4'h3});
			watchdog_mode_cfg <= cs[4:3];
			pulse(6'h20);
			cyc(2);
			rd(DCPM_OFS_STATUS, {6'h0, cs[1:0]}, 8'h03);
			pulse(6'h10);
			cyc(2);
			rd(DCPM_OFS_STATUS, cs[5] ? 8'h01 : {6'h0, cs[1:0]}, 8'h03);
			pulse(cs[2] ? 6'h08 : 6'h01);
			cyc(3);
			rd(DCPM_OFS_STATUS, 8'h01, 8'h03);
			rd(DCPM_OFS_CLK_CTL, {3'h0, cs[6], 4'h3}, 8'hff);
		end
		$display("test sleep modes done");
		print_verdict();
	end
endmodule // dcpm_clock_ctrl_bench
bind dcpm_clock_ctrl dcpm_clock_ctrl_sva i_sva (.core_clk, .rst, .reg_rd_en, .reg_rd_data,
	.trim_default, .slow_osc_tick, .fast_osc_tick, .watchdog_mode_cfg, .sleep_req,
	.ext_pin_irq, .pin_change_evt, .sysclk_tick, .timer_tick, .slow_osc_en, .fast_osc_en,
	.fast_rc_trim, .wakeup_timer_run, .watchdog_clk_run, .op_mode);

// *** tb/dcpm_clock_ctrl_sva.sv ***
// Purpose: port assertions for dcpm_clock_ctrl
// Assumes: one clock domain, reset active high
// Notes: bound from the bench top file
`timescale 1ns/1ps
module dcpm_clock_ctrl_sva
	import dcpm_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_rd_data,
	input wire logic [6:0] trim_default,
	input wire logic slow_osc_tick,
	input wire logic fast_osc_tick,
	input wire logic [1:0] watchdog_mode_cfg,
	input wire logic sleep_req,
	input wire logic [2:0] ext_pin_irq,
	input wire logic pin_change_evt,
	input wire logic sysclk_tick,
	input wire logic timer_tick,
	input wire logic slow_osc_en,
	input wire logic fast_osc_en,
	input wire logic [6:0] fast_rc_trim,
	input wire logic wakeup_timer_run,
	input wire logic watchdog_clk_run,
	input dcpm_mode_t op_mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// either sleep mode
	logic asleep;
	assign asleep = op_mode inside {DCPM_IDLE, DCPM_STOP};
	a_rd_data_idle: assert property (!$past(reg_rd_en) |-> reg_rd_data == 8'h00)
		else $error("read data not zero outside answer cycle");
	a_reset_slow: assert property ($past(rst) |-> op_mode == DCPM_SLOW)
		else $error("not slow mode after reset");
	a_trim_strap: assert property ($past(rst) |=> fast_rc_trim == $past(trim_default))
		else $error("trim not loaded from strap");
	a_sleep_gated: assert property (asleep |-> !sysclk_tick && !timer_tick)
		else $error("clock tick while asleep");
	a_stop_all_off: assert property (op_mode == DCPM_STOP |->
		!slow_osc_en && !fast_osc_en && !wakeup_timer_run && !watchdog_clk_run)
		else $error("clock running in stop");
	a_wdt_no_stop: assert property (sleep_req && !asleep &&
		watchdog_mode_cfg == DCPM_WDT_ALWAYS |=> op_mode == DCPM_IDLE)
		else $error("watchdog mode three did not give idle");
	a_stop_hold: assert property (op_mode == DCPM_STOP && ext_pin_irq == 3'h0
		&& !pin_change_evt |=> op_mode == DCPM_STOP)
		else $error("stop left without pin event");
	a_sys_source: assert property (sysclk_tick |-> $past(slow_osc_tick) || $past(fast_osc_tick))
		else $error("sysclk tick without source edge");
	a_timer_source: assert property (timer_tick |->
		$past(slow_osc_tick && slow_osc_en) || $past(fast_osc_tick && fast_osc_en))
		else $error("timer tick without running source");
	a_fast_runs: assert property (op_mode == DCPM_FAST |-> fast_osc_en)
		else $error("fast mode with fast oscillator off");
	a_idle_slow: assert property (op_mode == DCPM_IDLE |-> slow_osc_en && !fast_osc_en)
		else $error("idle without slow oscillator");
endmodule // dcpm_clock_ctrl_sva

// *** tb/dcpm_osc_model.sv ***
// Purpose: behavioural slow and fast rc oscillators as core_clk ticks
// Assumes: spacing in core cycles, x2 edge every cycle
// Notes: a halted oscillator gives no edges at all
`timescale 1ns/1ps
module dcpm_osc_model #(
	parameter int SLOW_DIV = 8, // slow edge spacing
	parameter int FAST_DIV = 2 // fast edge spacing
) (
	input wire logic core_clk,
	input wire logic slow_osc_en,
	input wire logic fast_osc_en,
	output logic slow_osc_tick,
	output logic fast_osc_tick,
	output logic fast_x2_tick
);
	int scnt = 0; // slow phase
	int fcnt = 0; // fast phase
	initial {slow_osc_tick, fast_osc_tick, fast_x2_tick} = 3'h0;
	// phase restarts when halted, as a real rc start-up would
	always @(posedge core_clk) begin
		scnt <= slow_osc_en ? (scnt + 1) % SLOW_DIV : 0;
		fcnt <= fast_osc_en ? (fcnt + 1) % FAST_DIV : 0;
		slow_osc_tick <= slow_osc_en && scnt == SLOW_DIV - 1;
		fast_osc_tick <= fast_osc_en && fcnt == FAST_DIV - 1;
		fast_x2_tick <= fast_osc_en;
	end
endmodule // dcpm_osc_model
